// ---- hdl/dpd_core_sequencer.sv ----
/*
  Fetch, decode and execute sequencer of the signal processor core, with the
  accumulator, loop and coprocessor effects it owns. Assumes program memory
  answers a read within the same instruction cycle (data sampled at its end).
*/
// Notes on behaviour
// - Three stages: fetch, decode, execute overlap
// - One instruction cycle is two clocks
// - One word fetched per cycle; execute two later
// - ALU and simple moves take one cycle
// - DMAC, indexed moves two; program memory four
// - Flow changes take one to three cycles
// - Direct move, immediate load: two words, two
// - Short repeats: two words, second loads end/count
// - Long block repeat: three words, count then end
// - Immediate or direct push/pop: two words, three
// - Bit tests: two words, second is mask
// - Clear all, upper, low or extension
// - Set all, upper or low to ones
// - Sign extend fills extension from bit 31
// - Immediate shift amounts limited per kind
// - Sixteen-position shifts and rotate
// - Loop level pointer steps by one
// - Repeat loads loop registers and level itself
// - Double move pointers use own steps only
// - Coprocessor ops make one or two moves
`timescale 1ns/1ns
`include "dpd_defs.svh"
module dpd_core_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Program memory
  output logic [15:0] pm_addr,
  output logic pm_rd,
  input wire logic [15:0] pm_data,
  // Execute stage
  output logic exe_first,
  output logic [4:0] exe_op,
  output logic [15:0] exe_word,
  output logic [15:0] exe_ext1,
  output logic [15:0] exe_ext2,
  // Accumulator and status
  output logic [39:0] accum,
  output logic shift_bad,
  // Loop registers
  output logic [1:0] loop_level_pointer,
  output logic [15:0] loop_start_reg,
  output logic [15:0] loop_count_reg,
  output logic [15:0] loop_end_reg,
  // Coprocessor
  output logic [1:0] cop_moves,
  output logic cop_bad
);
  logic phase_q;
  logic [15:0] pc_q;
  logic dec_valid_q;
  logic [15:0] dec_word_q;
  logic [15:0] dec_addr_q;
  logic exe_first_q;
  dpd_pkg::dpd_op_e exe_op_q;
  logic [15:0] exe_word_q;
  logic [15:0] exe_addr_q;
  logic [15:0] exe_ext1_q;
  logic [15:0] exe_ext2_q;
  logic [2:0] exe_left_q;
  logic ext2_pend_q;
  logic [39:0] acc_q;
  logic shift_bad_q;
  logic [1:0] lvl_q;
  logic [15:0] lbeg_q;
  logic [15:0] lcnt_q;
  logic [15:0] lend_q;
  logic [1:0] cop_moves_q;
  logic cop_bad_q;
  logic tick;
  logic advance;
  logic do_exec;
  dpd_pkg::dpd_op_e dec_op;
  logic [1:0] dec_words;
  logic [1:0] sh_kind;
  logic [5:0] sh_amt;
  logic sh_ok;

  function automatic logic [1:0] f_words(input dpd_pkg::dpd_op_e op);
    case (op)
      dpd_pkg::DPD_OP_MOVDIR, dpd_pkg::DPD_OP_LDIMM: f_words = `DPD_WORDS_TWO;
      dpd_pkg::DPD_OP_REPB, dpd_pkg::DPD_OP_REPS: f_words = `DPD_WORDS_TWO;
      dpd_pkg::DPD_OP_REPBL: f_words = `DPD_WORDS_THREE;
      dpd_pkg::DPD_OP_PUSHI, dpd_pkg::DPD_OP_PUSHD: f_words = `DPD_WORDS_TWO;
      dpd_pkg::DPD_OP_BIT: f_words = `DPD_WORDS_TWO;
      default: f_words = `DPD_WORDS_ONE;
    endcase
  endfunction

  function automatic logic [2:0] f_cycles(input dpd_pkg::dpd_op_e op, input logic [15:0] w);
    case (op)
      dpd_pkg::DPD_OP_DMAC, dpd_pkg::DPD_OP_MOVIDX, dpd_pkg::DPD_OP_STKIDX:
        f_cycles = `DPD_CYC_TWO;
      dpd_pkg::DPD_OP_PRAM: f_cycles = `DPD_CYC_PRAM;
      dpd_pkg::DPD_OP_FLOW:
        f_cycles = (w[`DPD_FLOW_HI:`DPD_FLOW_LO] == 2'h0) ? `DPD_CYC_ONE
                   : {1'b0, w[`DPD_FLOW_HI:`DPD_FLOW_LO]};
      dpd_pkg::DPD_OP_MOVDIR, dpd_pkg::DPD_OP_LDIMM, dpd_pkg::DPD_OP_BIT:
        f_cycles = `DPD_CYC_TWO;
      dpd_pkg::DPD_OP_REPB, dpd_pkg::DPD_OP_REPS: f_cycles = `DPD_CYC_TWO;
      dpd_pkg::DPD_OP_REPBL, dpd_pkg::DPD_OP_PUSHI, dpd_pkg::DPD_OP_PUSHD:
        f_cycles = `DPD_CYC_THREE;
      default: f_cycles = `DPD_CYC_ONE;
    endcase
  endfunction

  // Pipeline moves only on the second clock of each instruction cycle
  assign tick = phase_q;
  assign advance = (exe_left_q <= `DPD_CYC_ONE);
  assign do_exec = tick && exe_first_q;
  assign dec_op = dpd_pkg::dpd_op_e'(dec_word_q[`DPD_OP_HI:`DPD_OP_LO]);
  assign dec_words = f_words(dec_op);
  // A long instruction fetches only its own third word
  assign pm_rd = advance || ext2_pend_q;
  assign pm_addr = pc_q;
  assign sh_kind = exe_word_q[`DPD_SH_KIND_HI:`DPD_SH_KIND_LO];
  assign sh_amt = exe_word_q[`DPD_SH_AMT_HI:`DPD_SH_AMT_LO];

  always_comb
  begin
    case (sh_kind)
      2'h0, 2'h2: sh_ok = (sh_amt != 6'h00) && (sh_amt <= `DPD_SH_MAX);
      2'h1: sh_ok = (sh_amt <= `DPD_SH_MAX);
      default: sh_ok = (sh_amt <= `DPD_SHL_MAX);
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end

  // Fetch, decode and execute stage registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_q <= 16'h0000;
      dec_valid_q <= 1'b0;
      dec_word_q <= 16'h0000;
      dec_addr_q <= 16'h0000;
      exe_first_q <= 1'b0;
      exe_op_q <= dpd_pkg::DPD_OP_NOP;
      exe_word_q <= 16'h0000;
      exe_addr_q <= 16'h0000;
      exe_ext1_q <= 16'h0000;
      exe_ext2_q <= 16'h0000;
      exe_left_q <= 3'h0;
      ext2_pend_q <= 1'b0;
    end
    else if (tick)
    begin
      if (!advance)
      begin
        exe_left_q <= exe_left_q - 3'h1;
        exe_first_q <= 1'b0;
        if (ext2_pend_q)
        begin
          exe_ext2_q <= pm_data;
          ext2_pend_q <= 1'b0;
          pc_q <= pc_q + 16'h0001;
        end
      end
      else
      begin
        pc_q <= pc_q + 16'h0001;
        dec_word_q <= pm_data;
        dec_addr_q <= pc_q;
        if (dec_valid_q)
        begin
          exe_first_q <= 1'b1;
          exe_op_q <= dec_op;
          exe_word_q <= dec_word_q;
          exe_addr_q <= dec_addr_q;
          // The decode-cycle fetch of a first extension already used one cycle
          exe_left_q <= f_cycles(dec_op, dec_word_q)
                        - ((dec_words != `DPD_WORDS_ONE) ? 3'h1 : 3'h0);
          // Word fetched while the head sat in decode is its first extension
          if (dec_words != `DPD_WORDS_ONE)
            exe_ext1_q <= pm_data;
          ext2_pend_q <= (dec_words == `DPD_WORDS_THREE);
          dec_valid_q <= (dec_words == `DPD_WORDS_ONE);
        end
        else
        begin
          exe_first_q <= 1'b0;
          exe_left_q <= 3'h0;
          dec_valid_q <= 1'b1;
        end
      end
    end
  end

  // Accumulator operations, applied at the end of the first execute cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q <= 40'h00_0000_0000;
      shift_bad_q <= 1'b0;
    end
    else if (do_exec)
    begin
      shift_bad_q <= 1'b0;
      case (exe_op_q)
        dpd_pkg::DPD_OP_ACC:
          case (exe_word_q[`DPD_ACC_SUB_HI:`DPD_ACC_SUB_LO])
            dpd_pkg::DPD_ACC_CLR_ALL: acc_q <= '0;
            dpd_pkg::DPD_ACC_CLR_UPPER: acc_q[39:16] <= '0;
            dpd_pkg::DPD_ACC_CLR_LOW: acc_q[15:0] <= '0;
            dpd_pkg::DPD_ACC_CLR_EXT: acc_q[39:32] <= '0;
            dpd_pkg::DPD_ACC_SET_ALL: acc_q <= '1;
            dpd_pkg::DPD_ACC_SET_UPPER: acc_q[39:16] <= '1;
            dpd_pkg::DPD_ACC_SET_LOW: acc_q[15:0] <= '1;
            dpd_pkg::DPD_ACC_SIGN_EXT: acc_q[39:32] <= {8{acc_q[31]}};
            default: acc_q <= acc_q;
          endcase
        dpd_pkg::DPD_OP_SHIFT:
          // An amount out of range leaves the accumulator untouched
          if (!sh_ok)
            shift_bad_q <= 1'b1;
          else
            case (sh_kind)
              2'h0: acc_q <= 40'($signed(acc_q) >>> sh_amt);
              2'h1: acc_q <= (acc_q << sh_amt) | (acc_q >> (6'd40 - sh_amt));
              2'h2: acc_q <= acc_q >> sh_amt;
              default: acc_q <= acc_q << sh_amt;
            endcase
        dpd_pkg::DPD_OP_SHIFT16:
          case (sh_kind)
            2'h0: acc_q <= 40'($signed(acc_q) >>> `DPD_SIXTEEN);
            2'h1: acc_q <= acc_q << `DPD_SIXTEEN;
            2'h2: acc_q <= acc_q >> `DPD_SIXTEEN;
            default: acc_q <= {acc_q[23:0], acc_q[39:24]};
          endcase
        default: acc_q <= acc_q;
      endcase
    end
  end

  // Loop registers; the third word of a long repeat lands as it is fetched
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lvl_q <= 2'h0;
      lbeg_q <= 16'h0000;
      lcnt_q <= 16'h0000;
      lend_q <= 16'h0000;
    end
    else if (do_exec)
    begin
      case (exe_op_q)
        dpd_pkg::DPD_OP_LSPDEC: lvl_q <= lvl_q - 2'h1;
        dpd_pkg::DPD_OP_LSPINC: lvl_q <= lvl_q + 2'h1;
        dpd_pkg::DPD_OP_REPB:
        begin
          lvl_q <= lvl_q + 2'h1;
          lbeg_q <= exe_addr_q + 16'h0002;
          lcnt_q <= {7'h00, exe_word_q[`DPD_REP_CNT_HI:`DPD_REP_CNT_LO]};
          lend_q <= exe_ext1_q;
        end
        dpd_pkg::DPD_OP_REPS:
        begin
          lvl_q <= lvl_q + 2'h1;
          lbeg_q <= exe_addr_q + 16'h0002;
          lend_q <= exe_addr_q + 16'h0002;
          lcnt_q <= exe_ext1_q;
        end
        dpd_pkg::DPD_OP_REPBL:
        begin
          lvl_q <= lvl_q + 2'h1;
          lbeg_q <= exe_addr_q + 16'h0003;
          lcnt_q <= exe_ext1_q;
          lend_q <= pm_data;
        end
        default: lvl_q <= lvl_q;
      endcase
    end
  end

  // Coprocessor move count and pointer pairing check
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cop_moves_q <= 2'h0;
      cop_bad_q <= 1'b0;
    end
    else if (do_exec)
    begin
      cop_moves_q <= 2'h0;
      cop_bad_q <= 1'b0;
      if (exe_op_q == dpd_pkg::DPD_OP_COP_ONE)
        cop_moves_q <= 2'h1;
      else if (exe_op_q == dpd_pkg::DPD_OP_COP_TWO)
      begin
        cop_moves_q <= 2'h2;
        cop_bad_q <= (exe_word_q[`DPD_COP_XP] != exe_word_q[`DPD_COP_XS_HI])
                  || (exe_word_q[`DPD_COP_YP] != exe_word_q[`DPD_COP_YS_HI]);
      end
    end
  end

  assign exe_first = exe_first_q;
  assign exe_op = exe_op_q;
  assign exe_word = exe_word_q;
  assign exe_ext1 = exe_ext1_q;
  assign exe_ext2 = exe_ext2_q;
  assign accum = acc_q;
  assign shift_bad = shift_bad_q;
  assign loop_level_pointer = lvl_q;
  assign loop_start_reg = lbeg_q;
  assign loop_count_reg = lcnt_q;
  assign loop_end_reg = lend_q;
  assign cop_moves = cop_moves_q;
  assign cop_bad = cop_bad_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_load;
    tick && advance && dec_valid_q;
  endsequence
  sequence s_exec(dpd_pkg::dpd_op_e op);
    do_exec && exe_op_q == op;
  endsequence

  property p_pipe;
    s_load |=> exe_first_q && exe_word_q == $past(dec_word_q);
  endproperty
  a_pipe: assert property (p_pipe) else $error("decode word not passed to execute");
  property p_half;
    !phase_q |=> pm_addr == $past(pm_addr);
  endproperty
  a_half: assert property (p_half) else $error("fetch address moved mid cycle");
  property p_fetch;
    tick && pm_rd |=> pm_addr == 16'($past(pm_addr) + 16'h0001);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not advance by one");
  property p_alu;
    exe_first_q && exe_op_q == dpd_pkg::DPD_OP_ALU |-> exe_left_q == 3'h1;
  endproperty
  a_alu: assert property (p_alu) else $error("alu op not single cycle");
  property p_pram;
    s_exec(dpd_pkg::DPD_OP_PRAM) |=> !advance [*4] ##1 advance;
  endproperty
  a_pram: assert property (p_pram) else $error("program memory move not four cycles");
  property p_hold;
    tick && !advance && !ext2_pend_q |-> !pm_rd ##1 pm_addr == $past(pm_addr) && !exe_first_q;
  endproperty
  a_hold: assert property (p_hold) else $error("fetch during stall");
  property p_clear;
    do_exec && exe_op_q == dpd_pkg::DPD_OP_ACC
      && exe_word_q[3:0] == dpd_pkg::DPD_ACC_CLR_ALL |=> acc_q == 40'h00_0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left bits set");
  property p_accum_sign_extend;
    do_exec && exe_op_q == dpd_pkg::DPD_OP_ACC
      && exe_word_q[3:0] == dpd_pkg::DPD_ACC_SIGN_EXT |=> acc_q[39:32] == {8{acc_q[31]}};
  endproperty
  a_accum_sign_extend: assert property (p_accum_sign_extend) else $error("sign extension wrong");
  property p_shbad;
    s_exec(dpd_pkg::DPD_OP_SHIFT) && !sh_ok |=> shift_bad_q && acc_q == $past(acc_q);
  endproperty
  a_shbad: assert property (p_shbad) else $error("bad shift amount acted");
  property p_lsp;
    s_exec(dpd_pkg::DPD_OP_LSPINC) |=> lvl_q == 2'($past(lvl_q) + 2'h1);
  endproperty
  a_lsp: assert property (p_lsp) else $error("loop level not incremented");
  property p_rep3;
    s_exec(dpd_pkg::DPD_OP_REPBL) |=> lcnt_q == $past(exe_ext1_q) && lend_q == $past(pm_data);
  endproperty
  a_rep3: assert property (p_rep3) else $error("long repeat loads wrong");
  property p_cop;
    s_exec(dpd_pkg::DPD_OP_COP_TWO) && exe_word_q[10] != exe_word_q[9] |=> cop_bad_q;
  endproperty
  a_cop: assert property (p_cop) else $error("pointer pairing not flagged");
endmodule

// ---- pkg/dpd_defs.svh ----
/*
  Constants of the core sequencer: field positions, cycle counts and
  accumulator widths. Assumes nothing; included by the core.
*/
`ifndef DPD_DEFS_SVH
`define DPD_DEFS_SVH

`define DPD_WORD_W 16
`define DPD_ACC_W 40
`define DPD_OP_HI 15
`define DPD_OP_LO 11
// Accumulator sub-operation field
`define DPD_ACC_SUB_HI 3
`define DPD_ACC_SUB_LO 0
// Shift kind and amount fields
`define DPD_SH_KIND_HI 7
`define DPD_SH_KIND_LO 6
`define DPD_SH_AMT_HI 5
`define DPD_SH_AMT_LO 0
`define DPD_SH_MAX 6'h20
`define DPD_SHL_MAX 6'h1f
`define DPD_SIXTEEN 6'h10
// Flow-change cycle field, 0 read as 1
`define DPD_FLOW_HI 1
`define DPD_FLOW_LO 0
// Block repeat short count field, up to 511
`define DPD_REP_CNT_HI 8
`define DPD_REP_CNT_LO 0
// Coprocessor double move pointer and step fields
`define DPD_COP_XP 10
`define DPD_COP_XS_HI 9
`define DPD_COP_XS_LO 8
`define DPD_COP_YP 7
`define DPD_COP_YS_HI 6
`define DPD_COP_YS_LO 5
// Words and cycles per group
`define DPD_CYC_ONE 3'h1
`define DPD_CYC_TWO 3'h2
`define DPD_CYC_THREE 3'h3
`define DPD_CYC_PRAM 3'h4
`define DPD_WORDS_ONE 2'h1
`define DPD_WORDS_TWO 2'h2
`define DPD_WORDS_THREE 2'h3

`endif

// ---- pkg/dpd_pkg.sv ----
/*
  Types of the core sequencer: instruction groups and accumulator operations.
  Assumes the opcode sits in the top five bits of the first program word.
*/
package dpd_pkg;
  typedef enum logic [4:0] {
    DPD_OP_NOP = 5'h00, DPD_OP_ALU = 5'h01, DPD_OP_MOVRR = 5'h02,
    DPD_OP_MOVIND = 5'h03, DPD_OP_DMAC = 5'h04, DPD_OP_MOVIDX = 5'h05,
    DPD_OP_STKIDX = 5'h06, DPD_OP_PRAM = 5'h07, DPD_OP_FLOW = 5'h08,
    DPD_OP_MOVDIR = 5'h09, DPD_OP_LDIMM = 5'h0a, DPD_OP_REPB = 5'h0b,
    DPD_OP_REPS = 5'h0c, DPD_OP_REPBL = 5'h0d, DPD_OP_PUSHI = 5'h0e,
    DPD_OP_PUSHD = 5'h0f, DPD_OP_BIT = 5'h10, DPD_OP_ACC = 5'h11,
    DPD_OP_SHIFT = 5'h12, DPD_OP_SHIFT16 = 5'h13, DPD_OP_LSPDEC = 5'h14,
    DPD_OP_LSPINC = 5'h15, DPD_OP_COP_ONE = 5'h16, DPD_OP_COP_TWO = 5'h17
  } dpd_op_e;
  typedef enum logic [3:0] {
    DPD_ACC_CLR_ALL = 4'h0, DPD_ACC_CLR_UPPER = 4'h1, DPD_ACC_CLR_LOW = 4'h2,
    DPD_ACC_CLR_EXT = 4'h3, DPD_ACC_SET_ALL = 4'h4, DPD_ACC_SET_UPPER = 4'h5,
    DPD_ACC_SET_LOW = 4'h6, DPD_ACC_SIGN_EXT = 4'h7
  } dpd_acc_e;
endpackage

// ---- tb/dpd_prog_mem.sv ----
/*
  Program memory model facing the core sequencer: 256 words, read combinationally.
  Assumes the bench fills mem before releasing reset and that the address holds all cycle.
*/
`timescale 1ns/1ns
module dpd_prog_mem (
  // Clock
  input wire logic sys_clk,
  // Program memory bus
  input wire logic [15:0] pm_addr,
  input wire logic pm_rd,
  output logic [15:0] pm_data
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;

  // Released bus shows the complement, so a stale word never passes for data
  always_comb pm_data = pm_rd ? mem[pm_addr[7:0]] : ~last_q;

  always_ff @(posedge sys_clk)
  begin
    if (pm_rd)
      last_q <= pm_data;
  end
endmodule

// ---- tb/dpd_core_pipeline_decoder_test.sv ----
/*
  Self-checking bench of the core sequencer: short programs, start times and effects.
  Assumes the sequencer and the program memory model; no branching is modelled.
*/
`timescale 1ns/1ns
module dpd_core_pipeline_decoder_test;
  logic sys_clk, reset_n, pm_rd, exe_first, shift_bad, cop_bad, prev_first;
  logic [15:0] pm_addr, pm_data, exe_word, exe_ext1, exe_ext2, prev_word;
  logic [15:0] loop_start_reg, loop_count_reg, loop_end_reg;
  logic [4:0] exe_op;
  logic [39:0] accum;
  logic [1:0] loop_level_pointer, cop_moves;
  int err_total, tests_run, clk_cnt, ns, cyc;
  int st_clk[64];
  logic [15:0] st_word[64], st_e1[64], st_e2[64], st_lbeg[64], st_lcnt[64], st_lend[64];
  logic [4:0] st_op[64];
  logic [39:0] st_acc[64];
  logic [1:0] st_lvl[64], st_cm[64];
  logic st_sb[64], st_cb[64];
  logic [15:0] hw[$], img[$];
  int hc[$], hn[$], ha[$];

  dpd_core_sequencer i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .exe_first(exe_first), .exe_op(exe_op),
    .exe_word(exe_word), .exe_ext1(exe_ext1), .exe_ext2(exe_ext2), .accum(accum),
    .shift_bad(shift_bad), .loop_level_pointer(loop_level_pointer),
    .loop_start_reg(loop_start_reg), .loop_count_reg(loop_count_reg),
    .loop_end_reg(loop_end_reg), .cop_moves(cop_moves), .cop_bad(cop_bad));
  dpd_prog_mem i_mem (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      clk_cnt <= 0;
    else
      clk_cnt <= clk_cnt + 1;
  end

  // Back-to-back one-cycle instructions keep exe_first high, so a new word marks a start
  always @(negedge sys_clk)
  begin
    if (!reset_n)
      ns = 0;
    else if (exe_first === 1'b1 && (!prev_first || exe_word !== prev_word) && ns < 64)
    begin
      st_clk[ns] = clk_cnt;
      st_word[ns] = exe_word;
      st_op[ns] = exe_op;
      st_e1[ns] = exe_ext1;
      st_e2[ns] = exe_ext2;
      st_acc[ns] = accum;
      st_sb[ns] = shift_bad;
      st_lvl[ns] = loop_level_pointer;
      st_lbeg[ns] = loop_start_reg;
      st_lcnt[ns] = loop_count_reg;
      st_lend[ns] = loop_end_reg;
      st_cm[ns] = cop_moves;
      st_cb[ns] = cop_bad;
      ns++;
    end
    prev_first = (exe_first === 1'b1) && reset_n;
    prev_word = exe_word;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic add(input logic [4:0] op, input logic [10:0] low, input int cy, input int nw,
    input logic [15:0] e1, input logic [15:0] e2);
    hw.push_back({op, low});
    hc.push_back(cy);
    hn.push_back(nw);
    ha.push_back(img.size());
    img.push_back({op, low});
    if (nw > 1)
      img.push_back(e1);
    if (nw > 2)
      img.push_back(e2);
  endtask

  // Loads the program, restarts the core and replays every instruction on a reference
  task automatic run_and_judge();
    logic [39:0] acc;
    logic [15:0] w, lbeg, lcnt, lend;
    logic [5:0] amt;
    logic [4:0] op;
    logic [1:0] lvl, cm;
    logic sb, ok;
    int k, a;
    acc = '0;
    lbeg = '0;
    lcnt = '0;
    lend = '0;
    lvl = '0;
    sb = 1'b0;
    k = 0;
    for (int j = 0; j < 256; j++)
      i_mem.mem[j] = (j < img.size()) ? img[j] : 16'h0000;
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    while (ns <= hw.size() && k < 400)
    begin
      @(negedge sys_clk);
      k++;
    end
    check("starts", 40'(ns), 40'(hw.size() + 1));
    check("first start", 40'(st_clk[0]), 40'(4));
    foreach (hw[i])
    begin
      w = hw[i];
      a = ha[i];
      op = w[15:11];
      amt = w[5:0];
      cm = 2'h0;
      check("order", 40'(st_word[i]), 40'(w));
      check("op", 40'(st_op[i]), 40'(op));
      check("gap", 40'(st_clk[i + 1] - st_clk[i]), 40'(2 * hc[i]));
      if (hn[i] > 1)
        check("ext1", 40'(st_e1[i]), 40'(img[a + 1]));
      if (hn[i] > 2)
        check("ext2", 40'(st_e2[i + 1]), 40'(img[a + 2]));
      sb = 1'b0;
      case (op)
        dpd_pkg::DPD_OP_ACC:
          case (w[3:0])
            4'h0: acc = '0;
            4'h1: acc[39:16] = '0;
            4'h2: acc[15:0] = '0;
            4'h3: acc[39:32] = '0;
            4'h4: acc = '1;
            4'h5: acc[39:16] = '1;
            4'h6: acc[15:0] = '1;
            default: acc[39:32] = {8{acc[31]}};
          endcase
        dpd_pkg::DPD_OP_SHIFT:
        begin
          ok = (w[7:6] == 2'h3) ? amt <= 31 : (w[7:6] == 2'h1) ? amt <= 32 : amt >= 1 && amt <= 32;
          sb = !ok;
          if (ok)
            case (w[7:6])
              2'h0: acc = $signed(acc) >>> amt;
              2'h1: acc = (acc << amt) | (acc >> (40 - amt));
              2'h2: acc = acc >> amt;
              default: acc = acc << amt;
            endcase
        end
        dpd_pkg::DPD_OP_SHIFT16:
          case (w[7:6])
            2'h0: acc = $signed(acc) >>> 16;
            2'h1: acc = acc << 16;
            2'h2: acc = acc >> 16;
            default: acc = (acc << 16) | (acc >> 24);
          endcase
        dpd_pkg::DPD_OP_REPS:
          {lcnt, lend, lbeg, lvl} = {img[a + 1], 16'(a + 2), 16'(a + 2), lvl + 2'h1};
        dpd_pkg::DPD_OP_REPB:
          {lcnt, lend, lbeg, lvl} = {7'h00, w[8:0], img[a + 1], 16'(a + 2), lvl + 2'h1};
        dpd_pkg::DPD_OP_REPBL:
          {lcnt, lend, lbeg, lvl} = {img[a + 1], img[a + 2], 16'(a + 3), lvl + 2'h1};
        dpd_pkg::DPD_OP_LSPINC: lvl = lvl + 2'h1;
        dpd_pkg::DPD_OP_LSPDEC: lvl = lvl - 2'h1;
        dpd_pkg::DPD_OP_COP_ONE: cm = 2'h1;
        dpd_pkg::DPD_OP_COP_TWO: cm = 2'h2;
        default: cm = 2'h0;
      endcase
      check("accum", st_acc[i + 1], acc);
      check("shift_bad", 40'(st_sb[i + 1]), 40'(sb));
      check("loops", 40'({st_lvl[i + 1], st_lbeg[i + 1], st_lcnt[i + 1]}),
        {6'h00, lvl, lbeg, lcnt});
      check("loop end", 40'(st_lend[i + 1]), 40'(lend));
      check("cop moves", 40'(st_cm[i + 1]), 40'(cm));
      if (op == dpd_pkg::DPD_OP_COP_TWO)
        check("cop bad", 40'(st_cb[i + 1]), 40'(!(w[10] == w[9] && w[7] == w[6])));
    end
    hw.delete();
    hc.delete();
    hn.delete();
    ha.delete();
    img.delete();
  endtask

  task automatic sc_timing();
    add(dpd_pkg::DPD_OP_ALU, 11'h001, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_MOVRR, 11'h0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_MOVIND, 11'h0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_DMAC, 11'h0, 2, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_MOVIDX, 11'h0, 2, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_STKIDX, 11'h0, 2, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_PRAM, 11'h0, 4, 1, 16'h0, 16'h0);
    for (int f = 0; f < 4; f++)
      add(dpd_pkg::DPD_OP_FLOW, 11'(f), (f == 0) ? 1 : f, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_MOVDIR, 11'h0, 2, 2, 16'habcd, 16'h0);
    add(dpd_pkg::DPD_OP_LDIMM, 11'h0, 2, 2, 16'h1234, 16'h0);
    add(dpd_pkg::DPD_OP_BIT, 11'h0, 2, 2, 16'h00f0, 16'h0);
    add(dpd_pkg::DPD_OP_PUSHI, 11'h0, 3, 2, 16'h5a5a, 16'h0);
    add(dpd_pkg::DPD_OP_PUSHD, 11'h0, 3, 2, 16'h0042, 16'h0);
    add(dpd_pkg::DPD_OP_ALU, 11'h002, 1, 1, 16'h0, 16'h0);
    run_and_judge();
  endtask

  task automatic sc_accum();
    logic [3:0] subs[13];
    subs = '{4'h4, 4'h1, 4'h5, 4'h2, 4'h3, 4'h7, 4'h0, 4'h6, 4'h7, 4'h4, 4'h0, 4'h5, 4'h6};
    foreach (subs[j])
      add(dpd_pkg::DPD_OP_ACC, {7'h00, subs[j]}, 1, 1, 16'h0, 16'h0);
    // A word equal to its predecessor would hide its own start from the sampler
    add(dpd_pkg::DPD_OP_ACC, 11'h003, 1, 1, 16'h0, 16'h0);
    for (int s = 0; s < 4; s++)
      add(dpd_pkg::DPD_OP_SHIFT16, 11'(((s + 1) % 4) << 6), 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_ALU, 11'h0, 1, 1, 16'h0, 16'h0);
    run_and_judge();
  endtask

  task automatic sc_shift();
    logic [7:0] sh[15];
    sh = '{8'hc4, 8'h00, 8'h21, 8'h61, 8'h80, 8'he0, 8'h45, 8'h01, 8'h81, 8'h40, 8'h20,
      8'hdf, 8'ha0, 8'h60, 8'h5f};
    add(dpd_pkg::DPD_OP_ACC, 11'h006, 1, 1, 16'h0, 16'h0);
    foreach (sh[j])
      add(dpd_pkg::DPD_OP_SHIFT, {3'h0, sh[j]}, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_ALU, 11'h0, 1, 1, 16'h0, 16'h0);
    run_and_judge();
  endtask

  task automatic sc_loop_cop();
    add(dpd_pkg::DPD_OP_REPS, 11'h0, 2, 2, 16'h0123, 16'h0);
    add(dpd_pkg::DPD_OP_LSPINC, 11'h0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_REPB, 11'h1ff, 2, 2, 16'h0456, 16'h0);
    add(dpd_pkg::DPD_OP_LSPDEC, 11'h0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_REPBL, 11'h0, 3, 3, 16'h789a, 16'h0bcd);
    add(dpd_pkg::DPD_OP_LSPINC, 11'h1, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_LSPDEC, 11'h1, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_COP_ONE, 11'h0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_COP_TWO, 11'h1c0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_COP_TWO, 11'h700, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_COP_TWO, 11'h200, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_COP_TWO, 11'h6a0, 1, 1, 16'h0, 16'h0);
    add(dpd_pkg::DPD_OP_ALU, 11'h0, 1, 1, 16'h0, 16'h0);
    run_and_judge();
  endtask

  // A hung pipeline stops producing starts; the ceiling covers all programs with margin
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge sys_clk);
      cyc++;
      if (cyc == 6000)
      begin
        err_total++;
        tally_and_finish();
      end
    end
  end

  initial
  begin
    err_total = 0;
    tests_run = 0;
    reset_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    sc_timing();
    sc_accum();
    sc_shift();
    sc_loop_cop();
    tally_and_finish();
  end
endmodule
